// File: rtl/mci_pkg.sv
// shared constants and types of the multiplier contention interlock
package mci_pkg;
  // cycles the multiplier stays busy after a multiply's memory access ends
  localparam logic [1:0] MM_BUSY_CYCLES      = 2'h2;
  // extra cycles a store of the accumulator waits past the busy phase
  localparam logic [1:0] STORE_TAIL_CYCLES   = 2'h1;
  // reset value of the busy counter
  localparam logic [1:0] BUSY_CNT_RESET      = 2'h0;

  // interlock sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_TAIL
  } mci_state_type;
endpackage : mci_pkg

// File: rtl/mci_busy_if.sv
// carrier of the multiplier busy phase between tracker and interlock
`timescale 1ns/1ps
`default_nettype none
interface mci_busy_if;
  logic busy;      // multiplier busy phase running
  logic busyLast;  // final cycle of the busy phase
  modport tracker (output busy, output busyLast);
  modport user    (input  busy, input  busyLast);
endinterface : mci_busy_if
`default_nettype wire

// File: rtl/mci_busy_tracker.sv
// multiplier busy phase tracker
`timescale 1ns/1ps
`default_nettype none
module mci_busy_tracker
  import mci_pkg::*;
(
  input  wire logic   clk,         // core clock
  input  wire logic   reset_n,     // synchronous reset, active low
  input  wire logic   mulMaDone,   // last cycle of a multiply's memory access
  mci_busy_if.tracker bus          // busy phase towards the interlock
);
  logic [1:0] busyCnt_r;
  logic [1:0] busyCnt_nxt;

  // reload on each multiply, then count down to idle
  assign busyCnt_nxt = mulMaDone ? MM_BUSY_CYCLES :
                       (busyCnt_r != 2'h0) ? busyCnt_r - 2'h1 : busyCnt_r;

  // counter flop
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busyCnt_r <= BUSY_CNT_RESET;
    end else begin
      busyCnt_r <= busyCnt_nxt;
    end
  end

  // busy flags, independent of slot boundaries
  assign bus.busy     = (busyCnt_r != 2'h0);
  assign bus.busyLast = (busyCnt_r == 2'h1);

  // busy for exactly two cycles after a lone multiply
  a_busy_two_cycles: assert property (@(posedge clk) disable iff (!reset_n)
    mulMaDone ##1 !mulMaDone |-> bus.busy ##1 (bus.busy && bus.busyLast))
    else $error("busy phase length wrong");

  a_busy_ends: assert property (@(posedge clk) disable iff (!reset_n)
    bus.busyLast && !mulMaDone |=> !bus.busy)
    else $error("busy phase did not end");
endmodule : mci_busy_tracker
`default_nettype wire

// File: rtl/mci_interlock.sv
// pipeline interlock for accumulator moves that follow a signed word multiply
`timescale 1ns/1ps
`default_nettype none
module mci_interlock
  import mci_pkg::*;
(
  input  wire logic clk,              // core clock, 10 MHz
  input  wire logic reset_n,          // synchronous reset, active low
  input  wire logic mulMaDone,        // last cycle of a multiply's access stage
  input  wire logic followerStart,    // follower enters its access stage
  input  wire logic followerIsStore,  // 1 store to memory, 0 load from register
  input  wire logic fetchReq,         // instruction fetch wants the bus
  output logic      fetchGrant,       // fetch may use the bus this cycle
  output logic      maActive,         // follower access stage in progress
  output logic      maDone,           // final cycle of the merged slot
  output logic      multiplierAccess, // accumulator moved to or from multiplier
  output logic      memWriteEn,       // memory write of the accumulator
  output logic      youngerStall,     // hold decode and execute of younger ones
  output logic      mulBusy           // multiplier busy phase, for observation
);
  mci_busy_if busyBus ();

  mci_state_type state_r;
  mci_state_type state_nxt;
  logic          kindStore_r;
  logic          kindStore_nxt;
  logic          tailCnt_r;
  logic          tailCnt_nxt;

  // busy phase bookkeeping
  mci_busy_tracker u_busy (
    .clk       (clk),
    .reset_n   (reset_n),
    .mulMaDone (mulMaDone),
    .bus       (busyBus)
  );

  // decode of the current follower; a start in the last busy cycle ends the wait at once
  wire startNow    = followerStart && (state_r == ST_IDLE);
  wire isStore     = startNow ? followerIsStore : kindStore_r;
  wire inBusyWait  = startNow || (state_r == ST_HOLD);
  wire busyEnd     = inBusyWait && busyBus.busyLast;
  wire collide     = startNow && busyBus.busy && !busyBus.busyLast;
  wire singleSlot  = startNow && !busyBus.busy;
  wire holdEndLoad = busyEnd && !isStore;
  wire holdEndStor = busyEnd && isStore;
  wire tailEnd     = (state_r == ST_TAIL) && tailCnt_r;
  wire finalCycle  = singleSlot || holdEndLoad || tailEnd;

  // next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (holdEndStor) begin
          state_nxt = ST_TAIL;
        end else if (collide) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (holdEndLoad) begin
          state_nxt = ST_IDLE;
        end else if (holdEndStor) begin
          state_nxt = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (tailEnd) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // kind latch and tail counter
  assign kindStore_nxt = startNow ? followerIsStore : kindStore_r;
  assign tailCnt_nxt   = holdEndStor ? (STORE_TAIL_CYCLES == 2'h1) :
                         (state_r == ST_TAIL) ? 1'b1 : 1'b0;

  // sequencer flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r     <= ST_IDLE;
      kindStore_r <= 1'b0;
      tailCnt_r   <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      kindStore_r <= kindStore_nxt;
      tailCnt_r   <= tailCnt_nxt;
    end
  end

  // stage outputs; access stage wins the bus over fetch
  assign maActive         = startNow || (state_r != ST_IDLE);
  assign maDone           = finalCycle;
  assign multiplierAccess = finalCycle;
  assign memWriteEn       = finalCycle && isStore;
  assign fetchGrant       = fetchReq && !maActive;
  assign youngerStall     = maActive;
  assign mulBusy          = busyBus.busy;

  // collision steps
  sequence s_storeCollide;
    followerStart && (state_r == ST_IDLE) && followerIsStore && busyBus.busy;
  endsequence

  sequence s_loadCollide;
    followerStart && (state_r == ST_IDLE) && !followerIsStore && busyBus.busy;
  endsequence

  // store slot: two held cycles, one for a start in the last busy cycle, then the write one cycle past the busy phase
  sequence s_storeMerged;
    !maDone ##1 !maDone ##1 (maDone && memWriteEn);
  endsequence

  sequence s_storeLate;
    !maDone ##1 (maDone && memWriteEn);
  endsequence

  // load slot: held once, then done with the last busy cycle
  sequence s_loadMerged;
    (maActive && !maDone) ##1 (maDone && !memWriteEn);
  endsequence

  a_store_tail_cycle: assert property (@(posedge clk) disable iff (!reset_n)
    s_storeCollide ##0 !busyBus.busyLast |-> s_storeMerged)
    else $error("store slot not one past busy");

  a_store_late_start: assert property (@(posedge clk) disable iff (!reset_n)
    s_storeCollide ##0 busyBus.busyLast |-> s_storeLate)
    else $error("late store slot not one past busy");

  a_load_ends_busy: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == ST_HOLD) && busyBus.busyLast && !kindStore_r |-> maDone && !memWriteEn)
    else $error("load slot not ending with busy");

  a_load_no_early: assert property (@(posedge clk) disable iff (!reset_n)
    s_loadCollide ##0 !busyBus.busyLast |-> s_loadMerged)
    else $error("load finished before busy ended");

  a_load_late_start: assert property (@(posedge clk) disable iff (!reset_n)
    s_loadCollide ##0 busyBus.busyLast |-> maDone && !memWriteEn)
    else $error("late load not ending with busy");

  a_free_single: assert property (@(posedge clk) disable iff (!reset_n)
    startNow && !busyBus.busy |-> maDone && multiplierAccess && (memWriteEn == followerIsStore))
    else $error("free slot not single cycle");

  a_fetch_blocked: assert property (@(posedge clk) disable iff (!reset_n)
    fetchReq && maActive && isStore |-> !fetchGrant)
    else $error("fetch granted during store access");

  a_fetch_load: assert property (@(posedge clk) disable iff (!reset_n)
    fetchReq && maActive && !isStore |-> !fetchGrant)
    else $error("fetch granted during load access");

  a_load_no_write: assert property (@(posedge clk) disable iff (!reset_n)
    maActive && !isStore |-> !memWriteEn)
    else $error("load from register wrote memory");

  a_stall_release: assert property (@(posedge clk) disable iff (!reset_n)
    maDone |=> (youngerStall == followerStart))
    else $error("stall not released after slot");

  a_stall_held: assert property (@(posedge clk) disable iff (!reset_n)
    maActive && !maDone |=> youngerStall)
    else $error("stall dropped inside slot");

  a_busy_visible: assert property (@(posedge clk) disable iff (!reset_n)
    mulMaDone |=> mulBusy [*2])
    else $error("busy not seen two cycles");

  // write and multiplier access only at the end of a slot
  a_write_final_only: assert property (@(posedge clk) disable iff (!reset_n)
    memWriteEn |-> maDone && isStore)
    else $error("memory write outside store slot end");

  a_access_at_end: assert property (@(posedge clk) disable iff (!reset_n)
    maDone |-> multiplierAccess && maActive)
    else $error("multiplier not accessed at slot end");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !maActive |-> !maDone && !memWriteEn && !multiplierAccess)
    else $error("access outside a stage");

  a_kind_latched: assert property (@(posedge clk) disable iff (!reset_n)
    startNow |=> (kindStore_r == $past(followerIsStore)))
    else $error("follower kind not kept");

  // hold and tail states against the busy phase
  a_tail_writes: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == ST_TAIL) |-> maDone && memWriteEn && !mulBusy)
    else $error("tail cycle not the store end");

  a_hold_in_busy: assert property (@(posedge clk) disable iff (!reset_n)
    (state_r == ST_HOLD) |-> mulBusy)
    else $error("held stage outside busy phase");

  a_slot_bounded: assert property (@(posedge clk) disable iff (!reset_n)
    startNow |-> ##[0:2] maDone)
    else $error("merged slot too long");

  // fetch and pipeline release
  a_fetch_free: assert property (@(posedge clk) disable iff (!reset_n)
    fetchReq && !maActive |-> fetchGrant)
    else $error("fetch refused while no access stage");

  a_idle_after_done: assert property (@(posedge clk) disable iff (!reset_n)
    maDone |=> (state_r == ST_IDLE))
    else $error("sequencer busy after slot end");
endmodule : mci_interlock
`default_nettype wire

// File: sim/mci_mul_model.sv
// multiplier unit model that ends a multiply's access stage
`timescale 1ns/1ps
`default_nettype none
module mci_mul_model (
  input  wire logic clk,       // core clock
  output var logic  mulMaDone  // last access cycle of a multiply
);
  initial mulMaDone = 1'b0;
  // one-cycle pulse, then the busy phase runs in the core
  task automatic issue;
    mulMaDone = 1'b1;
    @(posedge clk);
    #1 mulMaDone = 1'b0;
  endtask
endmodule // mci_mul_model
`default_nettype wire

// File: sim/mci_interlock_test.sv
// self-checking bench of the multiplier contention interlock
`timescale 1ns/1ps
`default_nettype none
module mci_interlock_test;
  typedef struct {int gap; logic st; int lat;} mci_row_type;
  logic clk = 1'b0, reset_n = 1'b0, followerStart = 1'b0, followerIsStore = 1'b0, fetchReq = 1'b1;
  logic mulMaDone, fetchGrant, maActive, maDone, multiplierAccess, memWriteEn, youngerStall, mulBusy;
  int   error_cnt = 0, n_compared = 0, n, i;
  // multiply-to-follower gap, store flag, extra cycles to merged slot end
  mci_row_type rows[6] = '{'{1, 1, 2}, '{1, 0, 1}, '{2, 1, 1}, '{2, 0, 0}, '{3, 1, 0}, '{0, 0, 0}};
  always #50 clk = ~clk;
  mci_mul_model mci_mul_model_inst (.clk(clk), .mulMaDone(mulMaDone));
  mci_interlock mci_interlock_inst (.clk(clk), .reset_n(reset_n), .mulMaDone(mulMaDone),
    .followerStart(followerStart), .followerIsStore(followerIsStore), .fetchReq(fetchReq),
    .fetchGrant(fetchGrant), .maActive(maActive), .maDone(maDone), .multiplierAccess(multiplierAccess),
    .memWriteEn(memWriteEn), .youngerStall(youngerStall), .mulBusy(mulBusy));
  // compare and count
  task automatic check(input string nm, input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // multiply unless gap is 0, then a follower after gap cycles; fetch requested throughout
  task automatic run(input int gap, input logic st, input int lat);
    if (gap > 0) begin
      mci_mul_model_inst.issue();
      repeat (gap - 1) step();
    end
    followerStart = 1'b1;
    followerIsStore = st;
    #1 check("mulBusy", mulBusy, gap inside {1, 2});
    n = 0;
    while (maDone !== 1'b1 && n < 8) begin
      check("stretch", youngerStall & maActive & !fetchGrant, 1'b1);
      step();
      followerStart = 1'b0;
      followerIsStore = !st;
      #1 n++;
    end
    check("slotEnd", n == lat, 1'b1);
    check("memWrite", memWriteEn, st);
    check("mulAccess", multiplierAccess, 1'b1);
    check("fetchBlocked", fetchGrant, 1'b0);
    step();
    followerStart = 1'b0;
    #1 check("resume", youngerStall | !fetchGrant, 1'b0);
  endtask
  // reset, table of cases, then a reset inside a stretched slot
  initial begin
    repeat (20) step();
    check("rstOut", maActive | maDone | mulBusy | memWriteEn | youngerStall, 1'b0);
    check("rstGrant", fetchGrant, 1'b1);
    reset_n = 1'b1;
    step();
    for (i = 0; i < 6; i++) begin
      run(rows[i].gap, rows[i].st, rows[i].lat);
      $display("test %0d done", i);
    end
    fetchReq = 1'b0;
    #1 check("noFetchReq", fetchGrant, 1'b0);
    fetchReq = 1'b1;
    mci_mul_model_inst.issue();
    followerStart = 1'b1;
    followerIsStore = 1'b1;
    step();
    reset_n = 1'b0;
    followerStart = 1'b0;
    step();
    #1 check("midReset", maActive | mulBusy | youngerStall, 1'b0);
    reset_n = 1'b1;
    run(rows[0].gap, rows[0].st, rows[0].lat);
    $display("test reset done");
    summarize();
  end
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule // mci_interlock_test
`default_nettype wire
